// file: rtl/cdsd_select_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "cdsd_defs.vh"

// Summary of operation
// - at cycle start the chosen port's address is gated into the predrive selection
// - address bit 2 picks the lower or upper 8K predrive set
// - bits 3,4,5 with Y current pulse pick one of eight columns and direction
// - bits 6 and 8 with a pulse pick one of four Y loops
// - bits 9,10,11 with X current pulse pick one of eight bands and direction
// - bits 12 to 15 with a pulse pick one of sixteen X lines
// - bit 9 picks upper or lower band section within the chosen half
// - X current predrive: bits 2,9 give top, bits 10,11 give bottom
// - each X current predrive serves four groups, only one active at once
// - write half uses opposite X current pulse, predrive pairs 0/3 and 1/2
// - sixteen X current groups in 4x4, each drives bands n and 7-n
// - each group has two unipolar pairs for half-bytes 0/2 and 1/3
// - bits 14,15 with voltage pulse pick one of eight X voltage predrives
// - X voltage predrive: bits 12,13 give top, bits 14,15 give bottom
// - X voltage predrive sinks byte 0 and sources byte 1, reversed on write
// - upper half bands are numbered 8 to 15 in the lower half positions
// - each bit plane is 64 groups of 16 by 8 cores, coded 0 to 7
// - every read half cycle is followed by a write half cycle
module cdsd_select_decoder (
   input wire clock,
   input wire rst,
   input wire clk_en,
   input wire cycle_start,
   input wire half_end,
   input wire [15:0] word_address_bits,
   input wire x_current_dir_pos_pulse,
   input wire x_current_dir_neg_pulse,
   input wire x_voltage_pos_pulse,
   input wire x_voltage_neg_pulse,
   input wire y_current_dir_pos_pulse,
   input wire y_current_dir_neg_pulse,
   input wire y_voltage_pos_pulse,
   input wire y_voltage_neg_pulse,
   output reg read_half,
   output reg write_half,
   output reg upper_half_sel,
   output reg [3:0] x_current_predrive_line,
   output reg [15:0] x_current_group,
   output reg [15:0] x_band_sel,
   output reg [1:0] x_current_source_switch,
   output reg [1:0] x_current_sink_switch,
   output reg [3:0] x_voltage_predrive_pn,
   output reg [3:0] x_voltage_predrive_np,
   output reg [15:0] x_line_sel,
   output reg [1:0] x_voltage_source_switch,
   output reg [1:0] x_voltage_sink_switch,
   output reg [7:0] y_current_predrive,
   output reg [7:0] y_column_sel,
   output reg y_current_dir_pos,
   output reg [7:0] y_voltage_predrive_pn,
   output reg [7:0] y_voltage_predrive_np,
   output reg [3:0] y_loop_sel,
   output reg polarity_fault
);
   reg [1:0] state;
   reg [1:0] next_state;
   reg [15:0] addr;

   // sequencer: a read half can only end into a write half
   always @* begin
      next_state = state;
      case (state)
         `CDSD_ST_IDLE: begin
            if (cycle_start) begin
               next_state = `CDSD_ST_READ;
            end
         end
         `CDSD_ST_READ: begin
            if (half_end) begin
               next_state = `CDSD_ST_WRITE;
            end
         end
         `CDSD_ST_WRITE: begin
            if (half_end) begin
               next_state = `CDSD_ST_IDLE;
            end
         end
         default: begin
            next_state = `CDSD_ST_IDLE;
         end
      endcase
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= `CDSD_RST_STATE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // address held for both halves so the write selects the same cores
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         addr <= `CDSD_RST_ADDR;
      end else if (clk_en && state == `CDSD_ST_IDLE && cycle_start) begin
         addr <= word_address_bits;
      end
   end

   wire active = (state == `CDSD_ST_READ) || (state == `CDSD_ST_WRITE);

   // a pair with both or neither pulse high selects nothing
   wire xc_en = active & (x_current_dir_pos_pulse ^ x_current_dir_neg_pulse);
   wire xv_en = active & (x_voltage_pos_pulse ^ x_voltage_neg_pulse);
   wire yc_en = active & (y_current_dir_pos_pulse ^ y_current_dir_neg_pulse);
   wire yv_en = active & (y_voltage_pos_pulse ^ y_voltage_neg_pulse);

   // X current: value {2,9,10,11}, inverted under the negative pulse
   wire [3:0] xc_raw = {addr[`CDSD_BIT_HALF], addr[`CDSD_BIT_XBAND0],
                        addr[`CDSD_BIT_XBAND1], addr[`CDSD_BIT_XBAND2]};
   wire [3:0] xc_val = x_current_dir_pos_pulse ? xc_raw : ~xc_raw;
   wire [15:0] xc_onehot;
   cdsd_matrix_decode #(.ROW_W(2), .COL_W(2)) u_xc (
      .en(xc_en),
      .row(xc_val[3:2]),
      .col(xc_val[1:0]),
      .onehot(xc_onehot)
   );

   // X voltage: value {12,13,14,15}, no inversion, pulse picks polarity
   wire [3:0] xv_val = {addr[`CDSD_BIT_XLINE0], addr[`CDSD_BIT_XLINE1],
                        addr[`CDSD_BIT_XLINE2], addr[`CDSD_BIT_XLINE3]};
   wire [15:0] xv_onehot;
   cdsd_matrix_decode #(.ROW_W(2), .COL_W(2)) u_xv (
      .en(xv_en),
      .row(xv_val[3:2]),
      .col(xv_val[1:0]),
      .onehot(xv_onehot)
   );

   // Y current: value {3,4,5}, inverted under the negative pulse
   wire [2:0] yc_raw = {addr[`CDSD_BIT_YCOL0], addr[`CDSD_BIT_YCOL1], addr[`CDSD_BIT_YCOL2]};
   wire [2:0] yc_val = y_current_dir_pos_pulse ? yc_raw : ~yc_raw;
   wire [7:0] yc_onehot;
   cdsd_matrix_decode #(.ROW_W(1), .COL_W(2)) u_yc (
      .en(yc_en),
      .row(yc_val[2:2]),
      .col(yc_val[1:0]),
      .onehot(yc_onehot)
   );

   // Y voltage string: value {2,6,8}; loop within the column from {6,8}
   wire [2:0] yv_val = {addr[`CDSD_BIT_HALF], addr[`CDSD_BIT_YLOOP0], addr[`CDSD_BIT_YLOOP1]};
   wire [7:0] yv_onehot;
   cdsd_matrix_decode #(.ROW_W(1), .COL_W(2)) u_yv (
      .en(yv_en),
      .row(yv_val[2:2]),
      .col(yv_val[1:0]),
      .onehot(yv_onehot)
   );

   // band numbers: half from bit 2 gives 8-15 in the same places as 0-7
   wire [3:0] band_num = xc_raw;
   wire [15:0] band_onehot;
   cdsd_matrix_decode #(.ROW_W(2), .COL_W(2)) u_band (
      .en(xc_en),
      .row(band_num[3:2]),
      .col(band_num[1:0]),
      .onehot(band_onehot)
   );

   reg [3:0] next_xc_line;
   reg [15:0] next_band;
   integer i;
   always @* begin
      next_xc_line = 4'h0;
      next_band = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
         // predrive k serves groups k, k+4, k+8, k+12
         next_xc_line[i % 4] = next_xc_line[i % 4] | xc_onehot[i];
         // band n and its complement 7-n within the same half
         next_band[i] = band_onehot[i] | band_onehot[(i & 8) | (7 - (i & 7))];
      end
   end

   // only a drive to the same line pair is legal with opposite current sense
   wire xv_same_sense = (x_current_dir_pos_pulse & x_voltage_pos_pulse) |
                        (x_current_dir_neg_pulse & x_voltage_neg_pulse);

   reg next_read_half;
   reg next_write_half;
   reg next_upper_half_sel;
   reg [15:0] next_x_current_group;
   reg [1:0] next_x_current_source_switch;
   reg [1:0] next_x_current_sink_switch;
   reg [3:0] next_x_voltage_predrive_pn;
   reg [3:0] next_x_voltage_predrive_np;
   reg [15:0] next_x_line_sel;
   reg [1:0] next_x_voltage_source_switch;
   reg [1:0] next_x_voltage_sink_switch;
   reg [7:0] next_y_current_predrive;
   reg [7:0] next_y_column_sel;
   reg next_y_current_dir_pos;
   reg [7:0] next_y_voltage_predrive_pn;
   reg [7:0] next_y_voltage_predrive_np;
   reg [3:0] next_y_loop_sel;
   reg next_polarity_fault;

   // sequencer status and the partner watch
   always @* begin
      next_read_half = (state == `CDSD_ST_READ);
      next_write_half = (state == `CDSD_ST_WRITE);
      next_upper_half_sel = active & addr[`CDSD_BIT_HALF];
      // a watch on the partner: X current and X voltage pulses must be opposite
      next_polarity_fault = active & xv_same_sense;
   end

   // upper/lower band section from bit 9 is part of the group number
   always @* begin
      next_x_current_group = xc_onehot;
      // both unipolar pairs (half-bytes 0/2 and 1/3) fire with the group
      next_x_current_source_switch = {2{xc_en}};
      next_x_current_sink_switch = {2{xc_en}};
      // a voltage predrive serves the lines that share its low two bits
      next_x_voltage_predrive_pn = {4{xv_en & x_voltage_pos_pulse}} & (4'h1 << xv_val[1:0]);
      next_x_voltage_predrive_np = {4{xv_en & x_voltage_neg_pulse}} & (4'h1 << xv_val[1:0]);
      next_x_line_sel = xv_onehot;
      // bit 0 is byte 0, bit 1 is byte 1; the opposite pulse swaps them
      next_x_voltage_sink_switch = {xv_en & x_voltage_pos_pulse, xv_en & x_voltage_neg_pulse};
      next_x_voltage_source_switch = {xv_en & x_voltage_neg_pulse, xv_en & x_voltage_pos_pulse};
   end

   // column from the raw address; the current predrive flips with the pulse
   always @* begin
      next_y_current_predrive = yc_onehot;
      next_y_column_sel = {8{yc_en}} & (8'h01 << yc_raw);
      next_y_current_dir_pos = yc_en & y_current_dir_pos_pulse;
      next_y_voltage_predrive_pn = {8{y_voltage_pos_pulse}} & yv_onehot;
      next_y_voltage_predrive_np = {8{y_voltage_neg_pulse}} & yv_onehot;
      next_y_loop_sel = {4{yv_en}} & (4'h1 << yv_val[1:0]);
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         read_half <= 1'b0;
         write_half <= 1'b0;
         upper_half_sel <= 1'b0;
         polarity_fault <= 1'b0;
      end else if (clk_en) begin
         read_half <= next_read_half;
         write_half <= next_write_half;
         upper_half_sel <= next_upper_half_sel;
         polarity_fault <= next_polarity_fault;
      end
   end

   // a low clock enable leaves the last selection standing on the switches
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         x_current_predrive_line <= 4'h0;
         x_current_group <= 16'h0000;
         x_band_sel <= 16'h0000;
         x_current_source_switch <= 2'h0;
         x_current_sink_switch <= 2'h0;
         x_voltage_predrive_pn <= 4'h0;
         x_voltage_predrive_np <= 4'h0;
         x_line_sel <= 16'h0000;
         x_voltage_source_switch <= 2'h0;
         x_voltage_sink_switch <= 2'h0;
      end else if (clk_en) begin
         x_current_predrive_line <= next_xc_line;
         x_current_group <= next_x_current_group;
         x_band_sel <= next_band;
         x_current_source_switch <= next_x_current_source_switch;
         x_current_sink_switch <= next_x_current_sink_switch;
         x_voltage_predrive_pn <= next_x_voltage_predrive_pn;
         x_voltage_predrive_np <= next_x_voltage_predrive_np;
         x_line_sel <= next_x_line_sel;
         x_voltage_source_switch <= next_x_voltage_source_switch;
         x_voltage_sink_switch <= next_x_voltage_sink_switch;
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         y_current_predrive <= 8'h00;
         y_column_sel <= 8'h00;
         y_current_dir_pos <= 1'b0;
         y_voltage_predrive_pn <= 8'h00;
         y_voltage_predrive_np <= 8'h00;
         y_loop_sel <= 4'h0;
      end else if (clk_en) begin
         y_current_predrive <= next_y_current_predrive;
         y_column_sel <= next_y_column_sel;
         y_current_dir_pos <= next_y_current_dir_pos;
         y_voltage_predrive_pn <= next_y_voltage_predrive_pn;
         y_voltage_predrive_np <= next_y_voltage_predrive_np;
         y_loop_sel <= next_y_loop_sel;
      end
   end
endmodule

`default_nettype wire

// file: common/cdsd_defs.vh
`ifndef CDSD_DEFS_VH
`define CDSD_DEFS_VH

// address bit positions, index n is address bit n
`define CDSD_BIT_HALF 2
`define CDSD_BIT_YCOL0 3
`define CDSD_BIT_YCOL1 4
`define CDSD_BIT_YCOL2 5
`define CDSD_BIT_YLOOP0 6
`define CDSD_BIT_YDIR 7
`define CDSD_BIT_YLOOP1 8
`define CDSD_BIT_XBAND0 9
`define CDSD_BIT_XBAND1 10
`define CDSD_BIT_XBAND2 11
`define CDSD_BIT_XLINE0 12
`define CDSD_BIT_XLINE1 13
`define CDSD_BIT_XLINE2 14
`define CDSD_BIT_XLINE3 15

// memory cycle sequencer states
`define CDSD_ST_IDLE 2'h0
`define CDSD_ST_READ 2'h1
`define CDSD_ST_WRITE 2'h2

// reset values
`define CDSD_RST_ADDR 16'h0000
`define CDSD_RST_STATE 2'h0

`endif

// file: rtl/cdsd_matrix_decode.v
`timescale 1ns/1ps
`default_nettype none

// row/column decoder: entry {row,col} is high only while en is high
module cdsd_matrix_decode #(
   parameter ROW_W = 2,
   parameter COL_W = 2
) (
   input wire en,
   input wire [ROW_W-1:0] row,
   input wire [COL_W-1:0] col,
   output wire [(1<<(ROW_W+COL_W))-1:0] onehot
);
   genvar g;
   generate
      for (g = 0; g < (1 << (ROW_W + COL_W)); g = g + 1) begin : g_entry
         localparam [ROW_W+COL_W-1:0] IDX = g;
         // top of the line from the row, bottom from the column: one entry only
         assign onehot[g] = en & (row == IDX[ROW_W+COL_W-1:COL_W]) & (col == IDX[COL_W-1:0]);
      end
   endgenerate
endmodule

`default_nettype wire

// file: bench/cdsd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cdsd_monitor (
   input wire clock,
   input wire rst,
   input wire cycle_start,
   input wire half_end,
   input wire [15:0] word_address_bits,
   input wire x_current_dir_pos_pulse,
   input wire x_current_dir_neg_pulse,
   input wire x_voltage_pos_pulse,
   input wire x_voltage_neg_pulse,
   input wire y_current_dir_pos_pulse,
   input wire y_current_dir_neg_pulse,
   input wire read_half,
   input wire write_half,
   input wire [15:0] x_current_group,
   input wire [15:0] x_line_sel,
   input wire [3:0] x_voltage_predrive_np,
   input wire [1:0] x_voltage_sink_switch,
   input wire [1:0] x_voltage_source_switch,
   input wire [7:0] y_column_sel,
   input wire polarity_fault
);
   reg [15:0] lat;
   reg [1:0] ph;
   wire busy = read_half | write_half;
   // the closing edge of a half is skipped: its selection depends on a state that is changing
   wire g = busy & ~half_end;
   wire [3:0] xn = {lat[2], lat[9], lat[10], lat[11]};
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         lat <= 16'h0000;
         ph <= 2'h0;
      end else if (ph == 2'h0) begin
         // back to back starts come while write_half still shows the old cycle
         if (cycle_start) begin
            lat <= word_address_bits;
            ph <= 2'h1;
         end
      end else if (half_end) begin
         ph <= (ph == 2'h1) ? 2'h2 : 2'h0;
      end
   end
   default clocking mon_clk @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_halves; read_half == $past(ph == 2'h1) && write_half == $past(ph == 2'h2); endproperty
   a_halves: assert property (p_halves) else $error("half flags out of step");
   property p_idle_quiet; !busy |->
      x_current_group == 16'h0000 && x_line_sel == 16'h0000 && y_column_sel == 8'h00; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("selection while idle");
   property p_wr_after_rd; $rose(write_half) |-> $past(read_half) && !read_half; endproperty
   a_wr_after_rd: assert property (p_wr_after_rd) else $error("write half without read half");
   property p_rd_to_wr; $fell(read_half) |-> write_half; endproperty
   a_rd_to_wr: assert property (p_rd_to_wr) else $error("read half not followed by write half");
   property p_xc_pos; g && x_current_dir_pos_pulse && !x_current_dir_neg_pulse |=>
      x_current_group == 16'h0001 << xn; endproperty
   a_xc_pos: assert property (p_xc_pos) else $error("x current group wrong");
   property p_xc_neg; g && x_current_dir_neg_pulse && !x_current_dir_pos_pulse |=>
      x_current_group == 16'h0001 << ~xn; endproperty
   a_xc_neg: assert property (p_xc_neg) else $error("x current complement wrong");
   property p_xv_neg; g && x_voltage_neg_pulse && !x_voltage_pos_pulse |=> x_voltage_predrive_np ==
      4'h1 << {lat[14], lat[15]} && x_voltage_sink_switch == 2'h1 && x_voltage_source_switch == 2'h2; endproperty
   a_xv_neg: assert property (p_xv_neg) else $error("x voltage predrive wrong");
   property p_x_line; g && (x_voltage_pos_pulse ^ x_voltage_neg_pulse) |=>
      x_line_sel == 16'h0001 << {lat[12], lat[13], lat[14], lat[15]}; endproperty
   a_x_line: assert property (p_x_line) else $error("x line wrong");
   property p_y_col; g && (y_current_dir_pos_pulse ^ y_current_dir_neg_pulse) |=>
      y_column_sel == 8'h01 << {lat[3], lat[4], lat[5]}; endproperty
   a_y_col: assert property (p_y_col) else $error("y column wrong");
   property p_fault; g && x_current_dir_pos_pulse && x_voltage_pos_pulse |=> polarity_fault; endproperty
   a_fault: assert property (p_fault) else $error("polarity fault missed");
endmodule
`default_nettype wire

// file: bench/cdsd_timing_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdsd_timing_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic go,
   input wire logic bad,
   input wire logic [3:0] dwell,
   input wire logic [15:0] addr,
   output logic cycle_start,
   output logic half_end,
   output logic [15:0] word_address_bits,
   output logic [7:0] pulses
);
   logic [5:0] t;
   logic [5:0] d;
   logic [15:0] a;
   logic b;
   logic rd;
   logic wr;
   logic yp;
   wire last = (t == 6'h03 + d + d);
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         t <= 6'h00;
         d <= 6'h01;
         a <= 16'h0000;
         b <= 1'b0;
      end else if (t == 6'h00 || last) begin
         t <= {5'h00, go};
         if (go) begin
            d <= {2'h0, dwell};
            a <= addr;
            b <= bad;
         end
      end else begin
         t <= t + 6'h01;
      end
   end
   // the address is only valid in the start cycle; elsewhere it is scrambled
   assign word_address_bits = cycle_start ? a : ~a;
   assign cycle_start = (t == 6'h01);
   assign rd = (t >= 6'h02) && (t <= 6'h01 + d);
   assign wr = (t >= 6'h03 + d) && (t <= 6'h02 + d + d);
   assign half_end = (t == 6'h02 + d) || last;
   assign yp = (rd & ~a[7]) | (wr & a[7]);
   // voltage pulses run opposite to current pulses; an injected fault makes only the X voltage pair match the X current pair
   assign pulses = {rd, wr, b ? rd : wr, b ? wr : rd, yp, (rd | wr) & ~yp, (rd | wr) & ~yp, yp};
endmodule
`default_nettype wire

// file: bench/core_driveline_select_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module core_driveline_select_decoder_test;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic bad = 1'b0;
   logic [3:0] dwell = 4'h1;
   logic [15:0] addr = 16'h0000;
   logic cycle_start;
   logic half_end;
   logic [15:0] word_address_bits;
   logic [7:0] pulses;
   wire [108:0] outs;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #2.5 clock = ~clock;
   cdsd_timing_model model (.clock(clock), .rst(rst), .go(go), .bad(bad), .dwell(dwell), .addr(addr),
      .cycle_start(cycle_start), .half_end(half_end), .word_address_bits(word_address_bits), .pulses(pulses));
   cdsd_select_decoder dut (.clock(clock), .rst(rst), .clk_en(1'b1), .cycle_start(cycle_start),
      .half_end(half_end), .word_address_bits(word_address_bits), .x_current_dir_pos_pulse(pulses[7]),
      .x_current_dir_neg_pulse(pulses[6]), .x_voltage_pos_pulse(pulses[5]), .x_voltage_neg_pulse(pulses[4]),
      .y_current_dir_pos_pulse(pulses[3]), .y_current_dir_neg_pulse(pulses[2]), .y_voltage_pos_pulse(pulses[1]),
      .y_voltage_neg_pulse(pulses[0]), .read_half(outs[108]), .write_half(outs[107]), .upper_half_sel(outs[106]),
      .x_current_predrive_line(outs[105:102]), .x_current_group(outs[101:86]), .x_band_sel(outs[85:70]),
      .x_current_source_switch(outs[69:68]), .x_current_sink_switch(outs[67:66]),
      .x_voltage_predrive_pn(outs[65:62]), .x_voltage_predrive_np(outs[61:58]), .x_line_sel(outs[57:42]),
      .x_voltage_source_switch(outs[41:40]), .x_voltage_sink_switch(outs[39:38]),
      .y_current_predrive(outs[37:30]), .y_column_sel(outs[29:22]), .y_current_dir_pos(outs[21]),
      .y_voltage_predrive_pn(outs[20:13]), .y_voltage_predrive_np(outs[12:5]), .y_loop_sel(outs[4:1]),
      .polarity_fault(outs[0]));
   function automatic logic [108:0] expect_outs(input logic [15:0] a, input logic rd, input logic f);
      logic [3:0] n;
      logic [3:0] k;
      logic [2:0] c;
      logic yp;
      logic xvp;
      n = {a[2], a[9], a[10], a[11]};
      k = rd ? n : ~n;
      c = {a[3], a[4], a[5]};
      yp = rd ^ a[7];
      xvp = rd ? f : !f;
      return {rd, !rd, a[2], 4'h1 << k[1:0], 16'h0001 << k, (16'h0001 << n) | (16'h0001 << {n[3], 3'h7 - n[2:0]}),
         4'hF, xvp ? 4'h1 << {a[14], a[15]} : 4'h0, xvp ? 4'h0 : 4'h1 << {a[14], a[15]},
         16'h0001 << {a[12], a[13], a[14], a[15]}, xvp ? 4'h6 : 4'h9, 8'h01 << (yp ? c : ~c), 8'h01 << c, yp,
         yp ? 8'h00 : 8'h01 << {a[2], a[6], a[8]}, yp ? 8'h01 << {a[2], a[6], a[8]} : 8'h00, 4'h1 << {a[6], a[8]}, f};
   endfunction
   task automatic check(input string what, input logic [108:0] seen, input logic [108:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic access(input logic [15:0] a, input logic [3:0] d, input logic f);
      int k;
      @(posedge clock);
      go <= 1'b1;
      addr <= a;
      dwell <= d;
      bad <= f;
      k = 0;
      do begin
         @(posedge clock);
         #1;
         k++;
      end while (!cycle_start && k < 100);
      if (!cycle_start) fail_count++;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      #1;
      check("read half selection", outs, expect_outs(a, 1'b1, f));
      repeat (d + 1) @(posedge clock);
      #1;
      check("write half selection", outs, expect_outs(a, 1'b0, f));
   endtask
   task automatic t_x_bands;
      for (int i = 0; i < 16; i++) begin
         access({i[3:0], i[0], i[1], i[2], 6'h15, i[3], 2'h0}, 4'h1, 1'b0);
      end
   endtask
   task automatic t_y_select;
      for (int i = 0; i < 64; i++) begin
         access({7'h2A, i[5:0], 3'h0}, 4'h2, 1'b0);
      end
   endtask
   task automatic t_slow_pair;
      access(16'hC3A4, 4'hF, 1'b0);
      access(16'h3C5B, 4'h3, 1'b0);
   endtask
   task automatic t_fault;
      access(16'h96E0, 4'h2, 1'b1);
      access(16'h96E0, 4'h1, 1'b0);
   endtask
   task automatic results;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      check("reset state", outs, 109'h0);
      t_x_bands();
      t_y_select();
      t_slow_pair();
      t_fault();
      results();
   end
endmodule
bind cdsd_select_decoder cdsd_monitor mon (.clock, .rst, .cycle_start, .half_end, .word_address_bits,
   .x_current_dir_pos_pulse, .x_current_dir_neg_pulse, .x_voltage_pos_pulse, .x_voltage_neg_pulse,
   .y_current_dir_pos_pulse, .y_current_dir_neg_pulse, .read_half, .write_half, .x_current_group, .x_line_sel,
   .x_voltage_predrive_np, .x_voltage_sink_switch, .x_voltage_source_switch, .y_column_sel, .polarity_fault);
`default_nettype wire
